// ---- shared/irq_group_pkg.sv ----
// Constants, register map and field layout of the group enable and flag block
// ---------------------------------------------------------------------------
// Summary of operation
// - Enabled line lets pending interrupt reach core
// - Disabled line blocks interrupt toward core; code blocks group_req only, its edge still sets event status and can raise irq
// - Disabled line still captures its pending flag
// - Peripheral interrupt sets the line's pending flag
// - Taken interrupt clears flag, sets group acknowledge
// - Software flag writes update flags, may set
// - Writing zero clears flag, cancels other pendings
// - Reading flags has no side effects
// - Enable bits 0..7 map lines 1..8
// - Flag bits 0..7 hold lines 1..8
// - All enable and flag registers reset zero
// - Group registers at indices 10h..17h, enable even
// ---------------------------------------------------------------------------
package irq_group_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned GROUPS     = 4;
  localparam int unsigned LINES      = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned IDX_W      = 6;
  localparam int unsigned GROUP_W    = 3;
  localparam int unsigned BYTE_SHIFT = 2;

  // ---------------------------------------------------------------------------
  // Register indices, byte address is index times four
  // ---------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_GROUP8_LINE_ENABLE    = 6'h10;
  localparam logic [IDX_W-1:0] IDX_GROUP8_PENDING_FLAGS  = 6'h11;
  localparam logic [IDX_W-1:0] IDX_GROUP9_LINE_ENABLE    = 6'h12;
  localparam logic [IDX_W-1:0] IDX_GROUP9_PENDING_FLAGS  = 6'h13;
  localparam logic [IDX_W-1:0] IDX_GROUP10_LINE_ENABLE   = 6'h14;
  localparam logic [IDX_W-1:0] IDX_GROUP10_PENDING_FLAGS = 6'h15;
  localparam logic [IDX_W-1:0] IDX_GROUP11_LINE_ENABLE   = 6'h16;
  localparam logic [IDX_W-1:0] IDX_GROUP11_PENDING_FLAGS = 6'h17;
  localparam logic [IDX_W-1:0] IDX_FIRST_GROUP           = IDX_GROUP8_LINE_ENABLE;
  localparam logic [IDX_W-1:0] IDX_EVENT_STATUS          = 6'h20;
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK            = 6'h21;
  localparam logic [IDX_W-1:0] IDX_GROUP_ACK             = 6'h22;
  localparam logic [IDX_W-1:0] IDX_CORE_VIEW             = 6'h23;

  // ---------------------------------------------------------------------------
  // Reset values and fields
  // ---------------------------------------------------------------------------
  localparam logic [15:0] GROUP_REG_RESET   = 16'h0000;
  localparam int unsigned VIEW_ACK_LSB      = 8;
  localparam int unsigned VIEW_LINE_LSB     = 16;
  localparam int unsigned VIEW_GROUP_LSB    = 24;

endpackage

// ---- shared/reg_req_if.sv ----
// Register request carrier between the bus port and the register core
`timescale 1ns/1ps
interface reg_req_if;
  import irq_group_pkg::*;

  logic              wr;
  logic [IDX_W-1:0]  idx;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              hit;

  modport port (output wr, output idx, output wdata, input rdata, input hit);
  modport regs (input wr, input idx, input wdata, output rdata, output hit);
endinterface

// ---- hdl/apb_reg_port.sv ----
// APB slave front end with one wait state and registered answer
`timescale 1ns/1ps
module apb_reg_port
  import irq_group_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic                   pready,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pslverr,
  reg_req_if.port                rq
);

  logic              pready_reg, pready_next;
  logic [DATA_W-1:0] prdata_reg, prdata_next;
  logic              pslverr_reg, pslverr_next;
  logic              misaligned;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  assign misaligned = |paddr[BYTE_SHIFT-1:0];
  assign rq.idx     = paddr[ADDR_W-1:BYTE_SHIFT];
  assign rq.wdata   = pwdata;
  // Write lands only on the edge where the master sees pready high
  assign rq.wr      = psel & penable & pwrite & pready_reg & ~pslverr_reg;

  always_comb begin
    pready_next  = psel & penable & ~pready_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (pready_next) begin
      pslverr_next = misaligned | ~rq.hit;
      prdata_next  = (pwrite || pslverr_next) ? '0 : rq.rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

endmodule // apb_reg_port

// ---- hdl/line_edge_detect.sv ----
// Rising edge detector for peripheral interrupt lines
`timescale 1ns/1ps
module line_edge_detect #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] prev_reg, prev_next;

  // A line held high raises one event, not one per cycle
  always_comb begin
    prev_next = level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise = level & ~prev_reg;

endmodule // line_edge_detect

// ---- hdl/irq_group_regs.sv ----
// Group line enable and pending flag registers with core request and acknowledge
`timescale 1ns/1ps
module irq_group_regs
  import irq_group_pkg::*;
#(
  parameter int unsigned NUM_GROUPS = GROUPS,
  parameter int unsigned NUM_LINES  = LINES
) (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [ADDR_W-1:0]               paddr,
  input  wire logic [DATA_W-1:0]               pwdata,
  output logic                                 pready,
  output logic [DATA_W-1:0]                    prdata,
  output logic                                 pslverr,
  input  wire logic [NUM_GROUPS*NUM_LINES-1:0] periph_irq,
  input  wire logic                            core_take,
  input  wire logic [GROUP_W-1:0]              core_take_group,
  output logic [NUM_GROUPS-1:0]                group_req,
  output logic                                 taken_valid,
  output logic [GROUP_W-1:0]                   taken_group,
  output logic [$clog2(NUM_LINES)-1:0]         taken_line,
  output logic                                 irq
);

  localparam int unsigned LW = $clog2(NUM_LINES);

  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  if (NUM_GROUPS < 1 || NUM_GROUPS > 8) begin : g_bad_groups
    $error("NUM_GROUPS must lie between 1 and 8");
  end
  if (NUM_LINES < 2 || NUM_LINES > 16) begin : g_bad_lines
    $error("NUM_LINES must lie between 2 and 16");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [NUM_GROUPS-1:0][NUM_LINES-1:0] en_reg, en_next;
  logic [NUM_GROUPS-1:0][NUM_LINES-1:0] flag_reg, flag_next;
  logic [NUM_GROUPS-1:0]                ack_reg, ack_next;
  logic [NUM_GROUPS-1:0]                stat_reg, stat_next;
  logic [NUM_GROUPS-1:0]                mask_reg, mask_next;
  logic [NUM_GROUPS-1:0]                req_reg, req_next;
  logic                                 irq_reg, irq_next;
  logic                                 tv_reg, tv_next;
  logic [GROUP_W-1:0]                   tg_reg, tg_next;
  logic [LW-1:0]                        tl_reg, tl_next;
  logic [NUM_GROUPS*NUM_LINES-1:0]      rise;
  logic [NUM_GROUPS-1:0][NUM_LINES-1:0] rise_grp;
  logic [NUM_GROUPS-1:0]                rise_any;

  reg_req_if rq ();

  // ---------------------------------------------------------------------------
  // Bus port and line capture
  // ---------------------------------------------------------------------------
  apb_reg_port u_port (
    .clk     (clk),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .rq      (rq.port)
  );

  line_edge_detect #(
    .W (NUM_GROUPS*NUM_LINES)
  ) u_edge (
    .clk   (clk),
    .rst   (rst),
    .level (periph_irq),
    .rise  (rise)
  );

  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_rise
    assign rise_grp[g] = rise[g*NUM_LINES +: NUM_LINES];
    assign rise_any[g] = |rise_grp[g];
  end

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_group_reg(input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] diff;
    diff = idx - IDX_FIRST_GROUP;
    is_group_reg = (idx >= IDX_FIRST_GROUP) &&
                   (diff < IDX_W'(2*NUM_GROUPS));
  endfunction

  function automatic logic [GROUP_W-1:0] group_of(input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] diff;
    diff = idx - IDX_FIRST_GROUP;
    group_of = diff[GROUP_W:1];
  endfunction

  // Odd index is the flag register, even index the enable register
  function automatic logic is_flag_reg(input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] diff;
    diff = idx - IDX_FIRST_GROUP;
    is_flag_reg = diff[0];
  endfunction

  // Lowest numbered line wins when several are pending
  function automatic logic [LW-1:0] low_line(input logic [NUM_LINES-1:0] v);
    low_line = '0;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (v[i]) begin
        low_line = LW'(i);
      end
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Read path, no side effects on any state
  // ---------------------------------------------------------------------------
  always_comb begin
    rq.rdata = '0;
    rq.hit   = 1'b0;
    if (is_group_reg(rq.idx)) begin
      rq.hit = 1'b1;
      for (int g = 0; g < NUM_GROUPS; g++) begin
        if (group_of(rq.idx) == GROUP_W'(g)) begin
          if (is_flag_reg(rq.idx)) begin
            rq.rdata = DATA_W'(flag_reg[g]);
          end else begin
            rq.rdata = DATA_W'(en_reg[g]);
          end
        end
      end
    end else begin
      case (rq.idx)
        IDX_EVENT_STATUS: begin
          rq.hit   = 1'b1;
          rq.rdata = DATA_W'(stat_reg);
        end
        IDX_EVENT_MASK: begin
          rq.hit   = 1'b1;
          rq.rdata = DATA_W'(mask_reg);
        end
        IDX_GROUP_ACK: begin
          rq.hit   = 1'b1;
          rq.rdata = DATA_W'(ack_reg);
        end
        IDX_CORE_VIEW: begin
          rq.hit = 1'b1;
          rq.rdata[NUM_GROUPS-1:0]                       = req_reg;
          rq.rdata[VIEW_ACK_LSB +: NUM_GROUPS]           = ack_reg;
          rq.rdata[VIEW_LINE_LSB +: LW]                  = tl_reg;
          rq.rdata[VIEW_GROUP_LSB +: GROUP_W]            = tg_reg;
        end
        default: begin
          rq.hit   = 1'b0;
          rq.rdata = '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Next state of enables, flags, acknowledge and events
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [LW-1:0] pick;
    pick      = '0;
    en_next   = en_reg;
    flag_next = flag_reg;
    ack_next  = ack_reg;
    stat_next = stat_reg;
    mask_next = mask_reg;
    tv_next   = 1'b0;
    tg_next   = tg_reg;
    tl_next   = tl_reg;

    // Software writes come first so that any hardware set below wins
    if (rq.wr && is_group_reg(rq.idx)) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        if (group_of(rq.idx) == GROUP_W'(g)) begin
          if (is_flag_reg(rq.idx)) begin
            // Whole register written, zeros cancel pending lines
            flag_next[g] = rq.wdata[NUM_LINES-1:0];
          end else begin
            en_next[g] = rq.wdata[NUM_LINES-1:0];
          end
        end
      end
    end
    if (rq.wr && rq.idx == IDX_EVENT_STATUS) begin
      stat_next = stat_reg & ~rq.wdata[NUM_GROUPS-1:0];
    end
    if (rq.wr && rq.idx == IDX_EVENT_MASK) begin
      mask_next = rq.wdata[NUM_GROUPS-1:0];
    end
    if (rq.wr && rq.idx == IDX_GROUP_ACK) begin
      ack_next = ack_reg & ~rq.wdata[NUM_GROUPS-1:0];
    end

    // Core takes the lowest enabled pending line of the requested group
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (core_take && core_take_group == GROUP_W'(g) && req_reg[g]) begin
        pick               = low_line(flag_reg[g] & en_reg[g]);
        flag_next[g][pick] = 1'b0;
        ack_next[g]        = 1'b1;
        tv_next            = 1'b1;
        tg_next            = GROUP_W'(g);
        tl_next            = pick;
      end
    end

    // Capture regardless of enable; set beats any clear this cycle
    for (int g = 0; g < NUM_GROUPS; g++) begin
      flag_next[g] = flag_next[g] | rise_grp[g];
      stat_next[g] = stat_next[g] | rise_any[g];
    end
  end

  // ---------------------------------------------------------------------------
  // Core request and interrupt line
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      // Held off while the group acknowledge is set, as the core expects
      req_next[g] = |(flag_next[g] & en_next[g]) & ~ack_next[g];
    end
    irq_next = |(stat_next & mask_next);
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        en_reg[g]   <= GROUP_REG_RESET[NUM_LINES-1:0];
        flag_reg[g] <= GROUP_REG_RESET[NUM_LINES-1:0];
      end
      ack_reg  <= '0;
      stat_reg <= '0;
      mask_reg <= '0;
      req_reg  <= '0;
      irq_reg  <= 1'b0;
      tv_reg   <= 1'b0;
      tg_reg   <= '0;
      tl_reg   <= '0;
    end else begin
      en_reg   <= en_next;
      flag_reg <= flag_next;
      ack_reg  <= ack_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      req_reg  <= req_next;
      irq_reg  <= irq_next;
      tv_reg   <= tv_next;
      tg_reg   <= tg_next;
      tl_reg   <= tl_next;
    end
  end

  assign group_req   = req_reg;
  assign irq         = irq_reg;
  assign taken_valid = tv_reg;
  assign taken_group = tg_reg;
  assign taken_line  = tl_reg;

endmodule // irq_group_regs

// ---- dv/irq_group_chk.sv ----
// Port checker for the group enable and flag block
`timescale 1ns/1ps
module irq_group_chk
  import irq_group_pkg::*;
#(
  parameter int unsigned NUM_GROUPS = GROUPS,
  parameter int unsigned NUM_LINES  = LINES
) (
  input wire logic                            clk,
  input wire logic                            rst,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic                            pready,
  input wire logic [DATA_W-1:0]               prdata,
  input wire logic [NUM_GROUPS*NUM_LINES-1:0] periph_irq,
  input wire logic                            core_take,
  input wire logic [GROUP_W-1:0]              core_take_group,
  input wire logic [NUM_GROUPS-1:0]           group_req,
  input wire logic                            taken_valid,
  input wire logic [GROUP_W-1:0]              taken_group,
  input wire logic [$clog2(NUM_LINES)-1:0]    taken_line,
  input wire logic                            irq
);
  // ----
  // Helper logic
  // ----
  logic [NUM_GROUPS*NUM_LINES-1:0] line_q;
  logic [NUM_GROUPS*NUM_LINES-1:0] line_rise;
  logic [NUM_GROUPS-1:0]           grp_cause;
  logic                            wr_done;
  logic                            any_cause;
  logic                            take_ok;
  always_ff @(posedge clk) line_q <= rst ? '0 : periph_irq;
  assign line_rise = periph_irq & ~line_q;
  assign wr_done   = psel && penable && pready && pwrite;
  assign any_cause = (|line_rise) || wr_done;
  assign take_ok   = core_take && group_req[core_take_group[1:0]];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  take_hit_a: assert property (take_ok |=> taken_valid)
    else $error("accepted take gave no pulse");
  take_pair_a: assert property (taken_valid |-> $past(take_ok) && $past(core_take_group) == taken_group)
    else $error("taken pulse without matching take");
  ack_block_a: assert property (taken_valid |-> !group_req[taken_group[1:0]])
    else $error("group request stayed after take");
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("bus answer not after one wait state");
  rst_quiet_a: assert property ($fell(rst) |-> group_req == '0 && !irq && !pready && !taken_valid)
    else $error("outputs not quiet after reset");
  irq_cause_a: assert property ($rose(irq) |-> $past(any_cause) || $past(any_cause, 2))
    else $error("interrupt rose without cause");
  taken_hold_a: assert property ($changed(taken_group) || $changed(taken_line) |-> taken_valid)
    else $error("taken fields moved without take");
  rdata_hold_a: assert property ($changed(prdata) |-> pready)
    else $error("read data moved outside an answer");
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : gc
    assign grp_cause[g] = (|line_rise[g*NUM_LINES +: NUM_LINES]) || wr_done;
    req_cause_a: assert property ($rose(group_req[g]) |-> $past(grp_cause[g]) || $past(grp_cause[g], 2))
      else $error("group request rose without cause");
  end
  cover property (take_ok);
  cover property ($rose(irq));
  cover property ($rose(group_req[1]));
endmodule // irq_group_chk
bind irq_group_regs irq_group_chk #(.NUM_GROUPS(NUM_GROUPS), .NUM_LINES(NUM_LINES)) chk_i (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .prdata(prdata), .periph_irq(periph_irq), .core_take(core_take),
  .core_take_group(core_take_group), .group_req(group_req), .taken_valid(taken_valid),
  .taken_group(taken_group), .taken_line(taken_line), .irq(irq));

// ---- dv/core_model.sv ----
// Behavioural processor core that takes group requests after a set lag
`timescale 1ns/1ps
module core_model
  import irq_group_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              en,
  input  wire logic [3:0]        lag,
  input  wire logic [GROUPS-1:0] group_req,
  output logic                   core_take,
  output logic [GROUP_W-1:0]     core_take_group
);
  // ----
  // Take engine, idles one cycle after a take so the dropped request is seen
  // ----
  logic [3:0] wait_cnt;
  always_ff @(posedge clk) begin
    core_take <= 1'b0;
    if (rst) begin
      wait_cnt        <= 4'h0;
      core_take_group <= '0;
    end else if (core_take || !en || group_req == '0) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= lag) begin
      core_take <= 1'b1;
      for (int g = GROUPS - 1; g >= 0; g--)
        if (group_req[g]) core_take_group <= GROUP_W'(g);
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // core_model

// ---- dv/tb.sv ----
// Self-checking bench for the group enable and flag block
`timescale 1ns/1ps
module tb;
  import irq_group_pkg::*;
  // ----
  // Signals, design and core model
  // ----
  logic               clk, rst, psel, penable, pwrite, take_en, pready, pslverr;
  logic               core_take, taken_valid, irq, err;
  logic [ADDR_W-1:0]  paddr;
  logic [DATA_W-1:0]  pwdata, prdata, q;
  logic [31:0]        periph_irq;
  logic [3:0]         group_req, lag;
  logic [GROUP_W-1:0] core_take_group, taken_group;
  logic [2:0]         taken_line;
  int                 error_cnt, n_checks;
  irq_group_regs uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .periph_irq(periph_irq), .core_take(core_take), .core_take_group(core_take_group),
    .group_req(group_req), .taken_valid(taken_valid), .taken_group(taken_group),
    .taken_line(taken_line), .irq(irq));
  core_model pm (.clk(clk), .rst(rst), .en(take_en), .lag(lag), .group_req(group_req),
    .core_take(core_take), .core_take_group(core_take_group));
  function automatic logic [7:0] ba(input logic [5:0] i);
    return {i, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    // Data and error flag apart, so a refused read cannot pass as a zero
    chk(q, exp);
    chk({31'h0, err}, 32'h0);
  endtask
  task automatic pins(input logic [4:0] exp);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({27'h0, irq, group_req}, {27'h0, exp});
    @(posedge clk);
  endtask
  task automatic pulse(input int b);
    periph_irq[b] <= 1'b1;
    @(posedge clk);
    periph_irq[b] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_take;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (taken_valid !== 1'b1 && n < 40);
    chk({31'h0, taken_valid}, 32'h1);
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end
  // ----
  // Test sequence
  // ----
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    periph_irq = '0;
    take_en = 1'b0;
    lag = 4'h0;
    error_cnt = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 16; i < 24; i++) rd(ba(6'(i)), 32'h0);
    for (int i = 32; i < 36; i++) rd(ba(6'(i)), 32'h0);
    // Distinct values expose aliased offsets; upper bits must read back zero
    for (int i = 0; i < 4; i++) apb(1'b1, ba(6'(16 + 2 * i)), {24'hffffff, 8'(8'h81 + 17 * i)});
    for (int i = 0; i < 4; i++) rd(ba(6'(16 + 2 * i)), {24'h0, 8'(8'h81 + 17 * i)});
    for (int i = 0; i < 4; i++) apb(1'b1, ba(6'(16 + 2 * i)), 32'h0);
    apb(1'b0, 8'hc0, 32'h0);
    chk({q[31:1], err}, 32'h1);
    apb(1'b1, 8'h49, 32'hff);
    chk({31'h0, err}, 32'h1);
    pulse(8);
    pulse(15);
    rd(ba(IDX_GROUP9_PENDING_FLAGS), 32'h81);
    rd(ba(IDX_GROUP9_PENDING_FLAGS), 32'h81);
    pins(5'h00);
    take_en <= 1'b1;
    apb(1'b1, ba(IDX_GROUP9_LINE_ENABLE), 32'h1);
    wait_take;
    chk({26'h0, taken_group, taken_line}, 32'h8);
    rd(ba(IDX_GROUP9_PENDING_FLAGS), 32'h80);
    rd(ba(IDX_CORE_VIEW), 32'h0100_0200);
    apb(1'b1, ba(IDX_GROUP10_PENDING_FLAGS), 32'h4);
    rd(ba(IDX_GROUP10_PENDING_FLAGS), 32'h4);
    apb(1'b1, ba(IDX_GROUP10_PENDING_FLAGS), 32'h1);
    rd(ba(IDX_GROUP10_PENDING_FLAGS), 32'h1);
    apb(1'b1, ba(IDX_GROUP_ACK), 32'h2);
    lag <= 4'h5;
    apb(1'b1, ba(IDX_GROUP10_PENDING_FLAGS), 32'h5);
    apb(1'b1, ba(IDX_GROUP10_LINE_ENABLE), 32'h4);
    wait_take;
    chk({26'h0, taken_group, taken_line}, 32'h12);
    rd(ba(IDX_GROUP10_PENDING_FLAGS), 32'h1);
    rd(ba(IDX_CORE_VIEW), 32'h0202_0400);
    // Peripheral edge lands on the same edge as the clearing write
    fork
      apb(1'b1, ba(IDX_GROUP11_PENDING_FLAGS), 32'h0);
      begin
        @(posedge clk iff (psel && penable && !pready));
        periph_irq[24] <= 1'b1;
      end
    join
    periph_irq[24] <= 1'b0;
    rd(ba(IDX_GROUP11_PENDING_FLAGS), 32'h1);
    rd(ba(IDX_EVENT_STATUS), 32'ha);
    apb(1'b1, ba(IDX_EVENT_MASK), 32'h4);
    pins(5'h00);
    apb(1'b1, ba(IDX_EVENT_MASK), 32'h8);
    pins(5'h10);
    apb(1'b1, ba(IDX_EVENT_STATUS), 32'hf);
    pins(5'h00);
    rd(ba(IDX_EVENT_STATUS), 32'h0);
    report_and_stop;
  end
endmodule // tb
